// *** logic/ups_bus_ctrl.v ***
// ULPI PHY-side bus controller: ownership, throttling and modes
//
// What this block does
// - Enter synchronous mode once clock is stable
// - Provide 60 MHz clock; may stop it
// - Ignore data for one turnaround cycle
// - Direction low by default, high to send
// - Direction and next high carry USB data
// - Next low sends RXCMD or read data
// - Direction held high in low-power, serial modes
// - Alternate modes give data fixed directions
// - Stop while device drives releases direction
// - Stop held high wakes to synchronous mode
// - Next with direction low requests next byte
// - Next with direction high marks valid byte
// - Next unused in low-power and serial modes
// - Carry chirp, packets, registers and RXCMDs
// - Stop abort drops direction next cycle
`timescale 1ns/100ps
`include "ups_defines.vh"
module ups_bus_ctrl (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // ULPI pins
    output reg ulpi_clk_out,
    output reg dir_out,
    output reg nxt_out,
    input wire stp_in,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg [7:0] data_oe_out,
    // Mode control from the register side
    input wire [2:0] mode_sel_in,
    input wire clk_suspend_in,
    output reg wake_out,
    output wire [1:0] mode_out,
    output wire sync_mode_out,
    // Alternate-mode pin meanings
    input wire [7:0] alt_out_in,
    output reg [7:0] alt_in_out,
    // Bytes sent by the link
    input wire tx_ready_in,
    output reg [7:0] tx_byte_out,
    output reg tx_cmd_out,
    output reg tx_valid_out,
    output reg tx_end_out,
    // Received USB data for the link
    input wire rx_active_in,
    input wire rx_valid_in,
    input wire [7:0] rx_data_in,
    output wire rx_ready_out,
    output reg rx_abort_out,
    // Status updates and register read data
    input wire rxcmd_req_in,
    input wire [7:0] rxcmd_in,
    output reg rxcmd_ack_out,
    input wire regrd_req_in,
    input wire [7:0] regrd_data_in,
    output reg regrd_ack_out
);

    localparam ST_POWERUP = 3'h0;
    localparam ST_IDLE = 3'h1;
    localparam ST_LINK_TX = 3'h2;
    localparam ST_TURN_UP = 3'h3;
    localparam ST_SEND = 3'h4;
    localparam ST_ALT = 3'h5;

    ////////////////////////////////////////////////////////////////////////
    // Interface clock and tick

    reg [8:0] acc;
    reg clk_lvl;
    reg clk_stop;
    wire [8:0] acc_sum;
    wire wrap;
    wire tick;

    assign acc_sum = acc + `UPS_ACC_STEP;
    assign wrap = (acc_sum >= `UPS_ACC_WRAP);
    // One tick per rising edge of the interface clock
    assign tick = wrap & ~clk_lvl;

    reg [2:0] state;

    // Clock is gated only while low, so no runt pulse reaches the link
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            acc <= 9'h000;
            clk_lvl <= 1'b0;
            clk_stop <= 1'b0;
            ulpi_clk_out <= 1'b0;
        end else begin
            if (wrap) begin
                acc <= acc_sum - `UPS_ACC_WRAP;
                clk_lvl <= ~clk_lvl;
            end else begin
                acc <= acc_sum;
            end
            if (~clk_lvl) begin
                clk_stop <= (state == ST_ALT) & clk_suspend_in;
            end
            ulpi_clk_out <= (wrap ? ~clk_lvl : clk_lvl) & ~clk_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link pins into this domain

    wire [8:0] link_pins;
    wire link_stp;
    wire [7:0] link_data;

    ups_sync2 u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .pin_in({stp_in, data_in}),
        .sync_out(link_pins)
    );

    assign link_stp = link_pins[8];
    assign link_data = link_pins[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer

    wire buf_valid;
    wire [7:0] buf_data;
    reg pop;

    ups_rx_buf u_buf (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .in_valid_in(rx_valid_in),
        .in_data_in(rx_data_in),
        .in_ready_out(rx_ready_out),
        .out_valid_out(buf_valid),
        .out_data_out(buf_data),
        .out_ready_in(pop & tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus state

    reg [5:0] cnt;
    reg prev_dir;
    reg first;
    reg mode_hold;
    reg [1:0] alt_mode;
    reg [7:0] alt_mask;
    wire turn;
    wire rx_pending;
    reg mode_ok;
    reg [1:0] sel_mode;

    reg [2:0] next_state;
    reg next_dir;
    reg next_nxt;
    reg [7:0] next_data;
    reg [7:0] next_mask;
    reg [5:0] next_cnt;
    reg next_first;
    reg [1:0] next_mode;
    reg next_hold;
    reg [7:0] next_tx_byte;
    reg next_tx_cmd;
    reg next_tx_valid;
    reg next_tx_end;
    reg next_abort;
    reg next_rxcmd_ack;
    reg next_regrd_ack;
    reg next_wake;

    // Bus contents are meaningless in the cycle after a direction change
    assign turn = dir_out ^ prev_dir;
    assign rx_pending = rx_active_in | buf_valid | rxcmd_req_in
        | regrd_req_in;
    assign mode_out = (state == ST_ALT) ? alt_mode : `UPS_MODE_SYNC;
    assign sync_mode_out = (state != ST_ALT) & (state != ST_POWERUP);

    // Only a single selected mode is honoured
    always @* begin
        mode_ok = 1'b1;
        sel_mode = `UPS_MODE_SYNC;
        case (mode_sel_in)
            `UPS_SEL_LOWPWR: sel_mode = `UPS_MODE_LOWPWR;
            `UPS_SEL_SER6: sel_mode = `UPS_MODE_SER6;
            `UPS_SEL_SER3: sel_mode = `UPS_MODE_SER3;
            default: mode_ok = 1'b0;
        endcase
    end

    // Pins the device drives in each alternate mode
    always @* begin
        case (alt_mode)
            `UPS_MODE_LOWPWR: alt_mask = `UPS_MASK_LOWPWR;
            `UPS_MODE_SER6: alt_mask = `UPS_MASK_SER6;
            `UPS_MODE_SER3: alt_mask = `UPS_MASK_SER3;
            default: alt_mask = `UPS_MASK_SYNC;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic, evaluated for each interface clock cycle

    always @* begin
        next_state = state;
        next_dir = dir_out;
        next_nxt = 1'b0;
        next_data = data_out;
        next_mask = `UPS_MASK_SYNC;
        next_cnt = cnt;
        next_first = first;
        next_mode = alt_mode;
        next_hold = mode_hold & (mode_sel_in != 3'h0);
        next_tx_byte = tx_byte_out;
        next_tx_cmd = 1'b0;
        next_tx_valid = 1'b0;
        next_tx_end = 1'b0;
        next_abort = 1'b0;
        next_rxcmd_ack = 1'b0;
        next_regrd_ack = 1'b0;
        next_wake = 1'b0;
        pop = 1'b0;
        case (state)
            ST_POWERUP: begin
                // Bus blocked until the interface clock has settled
                next_dir = 1'b1;
                next_data = `UPS_DATA_IDLE;
                if (cnt == `UPS_STABLE_TICKS) begin
                    next_dir = 1'b0;
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt + 6'h01;
                end
            end
            ST_IDLE: begin
                next_dir = 1'b0;
                if (mode_ok & ~mode_hold) begin
                    next_dir = 1'b1;
                    next_mode = sel_mode;
                    next_state = ST_ALT;
                end else if (rx_pending) begin
                    next_dir = 1'b1;
                    next_state = ST_TURN_UP;
                end else if (~turn && link_data != `UPS_DATA_IDLE) begin
                    // Nonzero byte opens a link transfer
                    next_nxt = tx_ready_in;
                    next_first = 1'b1;
                    next_state = ST_LINK_TX;
                end
            end
            ST_LINK_TX: begin
                next_dir = 1'b0;
                if (link_stp) begin
                    next_tx_end = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    if (nxt_out) begin
                        // Byte on the bus while next was high is taken
                        next_tx_byte = link_data;
                        next_tx_valid = 1'b1;
                        next_tx_cmd = first;
                        next_first = 1'b0;
                    end
                    next_nxt = tx_ready_in;
                end
            end
            ST_TURN_UP: begin
                next_dir = 1'b1;
                next_data = rxcmd_in;
                if (link_stp) begin
                    next_dir = 1'b0;
                    next_abort = rx_active_in;
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_SEND;
                end
            end
            ST_SEND: begin
                next_dir = 1'b1;
                if (link_stp) begin
                    next_dir = 1'b0;
                    next_abort = rx_active_in | buf_valid;
                    next_state = ST_IDLE;
                end else if (buf_valid) begin
                    next_data = buf_data;
                    next_nxt = 1'b1;
                    pop = 1'b1;
                end else if (regrd_req_in) begin
                    // Read data takes the place of the status byte
                    next_data = regrd_data_in;
                    next_regrd_ack = 1'b1;
                end else if (rxcmd_req_in) begin
                    next_data = rxcmd_in;
                    next_rxcmd_ack = 1'b1;
                end else if (rx_active_in) begin
                    next_data = rxcmd_in;
                end else begin
                    next_dir = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            ST_ALT: begin
                next_dir = 1'b1;
                next_nxt = 1'b0;
                next_mask = alt_mask;
                next_data = alt_out_in & alt_mask;
                if (link_stp) begin
                    // Wake: return to synchronous mode
                    next_wake = 1'b1;
                    next_hold = 1'b1;
                    next_dir = 1'b0;
                    next_mask = `UPS_MASK_SYNC;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_dir = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers, advanced once per interface clock cycle

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_POWERUP;
            dir_out <= 1'b1;
            prev_dir <= 1'b1;
            nxt_out <= 1'b0;
            data_out <= `UPS_DATA_IDLE;
            data_oe_out <= 8'h00;
            cnt <= 6'h00;
            first <= 1'b0;
            alt_mode <= `UPS_MODE_SYNC;
            mode_hold <= 1'b0;
            alt_in_out <= 8'h00;
            tx_byte_out <= 8'h00;
        end else if (tick) begin
            state <= next_state;
            prev_dir <= dir_out;
            dir_out <= next_dir;
            nxt_out <= next_nxt;
            data_out <= next_data;
            // Drivers on only when direction was already high
            data_oe_out <= (next_dir & dir_out) ? next_mask : 8'h00;
            cnt <= next_cnt;
            first <= next_first;
            alt_mode <= next_mode;
            mode_hold <= next_hold;
            tx_byte_out <= next_tx_byte;
            if (state == ST_ALT) begin
                alt_in_out <= link_data & ~alt_mask;
            end
        end
    end

    // Event strobes last one system clock cycle
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            tx_cmd_out <= 1'b0;
            tx_valid_out <= 1'b0;
            tx_end_out <= 1'b0;
            rx_abort_out <= 1'b0;
            rxcmd_ack_out <= 1'b0;
            regrd_ack_out <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            tx_cmd_out <= tick & next_tx_cmd;
            tx_valid_out <= tick & next_tx_valid;
            tx_end_out <= tick & next_tx_end;
            rx_abort_out <= tick & next_abort;
            rxcmd_ack_out <= tick & next_rxcmd_ack;
            regrd_ack_out <= tick & next_regrd_ack;
            wake_out <= tick & next_wake;
        end
    end

endmodule // ups_bus_ctrl

// *** logic/ups_defines.vh ***
// Shared constants for the ULPI PHY-side bus controller
`ifndef UPS_DEFINES_VH
`define UPS_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// Clock generation
`define UPS_SYS_MHZ 200
`define UPS_ICLK_MHZ 60
// Phase accumulator: add twice the interface rate, wrap at the system rate
`define UPS_ACC_STEP 9'h078
`define UPS_ACC_WRAP 9'h0c8

////////////////////////////////////////////////////////////////////////////
// Start-up: interface clock cycles before the bus is released
`define UPS_STABLE_TICKS 6'h20

////////////////////////////////////////////////////////////////////////////
// Bus values
`define UPS_DATA_IDLE 8'h00

////////////////////////////////////////////////////////////////////////////
// Mode select bits and mode codes
`define UPS_SEL_LOWPWR 3'h1
`define UPS_SEL_SER6 3'h2
`define UPS_SEL_SER3 3'h4
`define UPS_MODE_SYNC 2'h0
`define UPS_MODE_LOWPWR 2'h1
`define UPS_MODE_SER6 2'h2
`define UPS_MODE_SER3 2'h3

////////////////////////////////////////////////////////////////////////////
// Data pins driven by the device in each mode
`define UPS_MASK_SYNC 8'hff
`define UPS_MASK_LOWPWR 8'hff
`define UPS_MASK_SER6 8'hf8
`define UPS_MASK_SER3 8'hf8

`endif

// *** logic/ups_rx_buf.v ***
// Two-entry receive buffer with valid and ready on both sides
`timescale 1ns/100ps
module ups_rx_buf (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Filling side
    input wire in_valid_in,
    input wire [7:0] in_data_in,
    output wire in_ready_out,
    // Draining side
    output wire out_valid_out,
    output wire [7:0] out_data_out,
    input wire out_ready_in
);
    reg [7:0] slot0;
    reg [7:0] slot1;
    reg [1:0] count;
    wire push;
    wire pop;

    assign in_ready_out = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign out_data_out = slot0;
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            slot0 <= 8'h00;
            slot1 <= 8'h00;
            count <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'h0) begin
                        slot0 <= in_data_in;
                    end else begin
                        slot1 <= in_data_in;
                    end
                    count <= count + 2'h1;
                end
                2'b01: begin
                    slot0 <= slot1;
                    count <= count - 2'h1;
                end
                2'b11: begin
                    if (count == 2'h1) begin
                        slot0 <= in_data_in;
                    end else begin
                        slot0 <= slot1;
                        slot1 <= in_data_in;
                    end
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end
endmodule // ups_rx_buf

// *** logic/ups_sync2.v ***
// Two-stage synchroniser for the link-driven pins
`timescale 1ns/100ps
module ups_sync2 (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Pins and their synchronised copy
    input wire [8:0] pin_in,
    output reg [8:0] sync_out
);
    reg [8:0] stage;

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            stage <= 9'h000;
            sync_out <= 9'h000;
        end else begin
            stage <= pin_in;
            sync_out <= stage;
        end
    end
endmodule // ups_sync2

// *** sim/ups_bus_ctrl_chk.sv ***
// Port-level checks for the ULPI PHY-side bus controller
`timescale 1ns/100ps
module ups_bus_ctrl_chk (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Observed ports
    input wire ulpi_clk_out,
    input wire dir_out,
    input wire nxt_out,
    input wire stp_in,
    input wire [7:0] data_out,
    input wire [7:0] data_oe_out,
    input wire [1:0] mode_out,
    input wire sync_mode_out,
    input wire wake_out,
    input wire rxcmd_ack_out,
    input wire [7:0] rxcmd_in,
    input wire regrd_ack_out,
    input wire [7:0] regrd_data_in
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_dir_on_tick: assert property ($changed(dir_out) |-> $rose(ulpi_clk_out))
        else $error("direction moved between interface clock edges");
    a_turn_quiet: assert property ($changed(dir_out) |-> data_oe_out == 8'h00)
        else $error("pins driven in a turnaround cycle");
    a_drive_owner: assert property (data_oe_out != 8'h00 |-> dir_out)
        else $error("pins driven while direction low");
    a_next_data: assert property (dir_out && nxt_out |-> data_oe_out == 8'hff)
        else $error("next high without a driven byte");
    a_alt_hold: assert property (mode_out != 2'h0 |-> dir_out && !nxt_out && !sync_mode_out)
        else $error("alternate mode without direction or with next");
    a_serial_mask: assert property (mode_out[1] && data_oe_out != 8'h00 |-> data_oe_out == 8'hf8)
        else $error("serial mode drives wrong pins");
    a_wake_sync: assert property ($rose(wake_out) |-> ##[0:10] (!dir_out && mode_out == 2'h0))
        else $error("wake did not return to synchronous mode");
    a_abort_drop: assert property ((sync_mode_out && dir_out && stp_in)[*4] |-> ##[0:10] !dir_out)
        else $error("stop did not release direction");
    a_status_byte: assert property (rxcmd_ack_out |-> dir_out && !nxt_out && data_out == rxcmd_in)
        else $error("status byte not on bus with next low");
    a_read_byte: assert property (regrd_ack_out |-> dir_out && !nxt_out && data_out == regrd_data_in)
        else $error("read data not on bus with next low");
endmodule // ups_bus_ctrl_chk
bind ups_bus_ctrl ups_bus_ctrl_chk u_chk (.clock_in(clock_in), .rst_in(rst_in),
    .ulpi_clk_out(ulpi_clk_out), .dir_out(dir_out), .nxt_out(nxt_out),
    .stp_in(stp_in), .data_out(data_out), .data_oe_out(data_oe_out),
    .mode_out(mode_out), .sync_mode_out(sync_mode_out), .wake_out(wake_out),
    .rxcmd_ack_out(rxcmd_ack_out), .rxcmd_in(rxcmd_in),
    .regrd_ack_out(regrd_ack_out), .regrd_data_in(regrd_data_in));

// *** sim/ups_bus_ctrl_tb.sv ***
// Self-checking bench for the ULPI PHY-side bus controller
`timescale 1ns/100ps
module ups_bus_ctrl_tb;
    logic clock_in = 0, rst_in = 1, tx_ready_in = 0, clk_suspend_in = 0;
    logic rx_active_in = 0, rx_valid_in = 0, rxcmd_req_in = 0, regrd_req_in = 0;
    logic [2:0] mode_sel_in = 0;
    logic [7:0] rx_data_in = 0, rxcmd_in = 0, regrd_data_in = 0, alt_out_in = 0;
    wire ulpi_clk_out, dir_out, nxt_out, stp_in, wake_out, sync_mode_out;
    wire rx_ready_out, tx_cmd_out, tx_valid_out, tx_end_out, rx_abort_out;
    wire rxcmd_ack_out, regrd_ack_out, link_oe;
    wire [7:0] data_out, data_oe_out, tx_byte_out, alt_in_out, link_d, bus_w;
    wire [1:0] mode_out;
    int n_fail = 0, num_checks = 0, seed = 32'hb788, i, j, k;
    logic [7:0] q[$], got[$], st, v, alt_lnk = 0;
    logic full_seen;
    logic [7:0] msk [0:2] = '{8'hff, 8'hf8, 8'hf8};
    // Released lines fall to the pull-downs
    // Link drives the undriven alternate-mode pins from alt_lnk
    assign bus_w = (data_oe_out & data_out)
        | (~data_oe_out & (link_oe ? link_d : alt_lnk));
    always #2.5 clock_in = ~clock_in;
    ups_bus_ctrl u_ups_bus_ctrl (.clock_in(clock_in), .rst_in(rst_in),
        .ulpi_clk_out(ulpi_clk_out), .dir_out(dir_out), .nxt_out(nxt_out),
        .stp_in(stp_in), .data_in(bus_w), .data_out(data_out),
        .data_oe_out(data_oe_out), .mode_sel_in(mode_sel_in),
        .clk_suspend_in(clk_suspend_in), .wake_out(wake_out), .mode_out(mode_out),
        .sync_mode_out(sync_mode_out), .alt_out_in(alt_out_in),
        .alt_in_out(alt_in_out), .tx_ready_in(tx_ready_in),
        .tx_byte_out(tx_byte_out), .tx_cmd_out(tx_cmd_out),
        .tx_valid_out(tx_valid_out), .tx_end_out(tx_end_out),
        .rx_active_in(rx_active_in), .rx_valid_in(rx_valid_in),
        .rx_data_in(rx_data_in), .rx_ready_out(rx_ready_out),
        .rx_abort_out(rx_abort_out), .rxcmd_req_in(rxcmd_req_in),
        .rxcmd_in(rxcmd_in), .rxcmd_ack_out(rxcmd_ack_out),
        .regrd_req_in(regrd_req_in), .regrd_data_in(regrd_data_in),
        .regrd_ack_out(regrd_ack_out));
    ups_link_model u_link (.clk_in(ulpi_clk_out), .dir_in(dir_out),
        .nxt_in(nxt_out), .stp_out(stp_in), .data_out(link_d), .oe_out(link_oe));
    //////////////////////////////////////////////////////////////////////
    task chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task test_done;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task cyc(input int c);
        repeat (c) @(negedge clock_in);
    endtask
    task cmp_q;
        chk(got.size() == q.size(), "byte count");
        foreach (q[x]) chk(got[x] === q[x], "byte value");
    endtask
    task dir_low;
        for (k = 0; k < 400 && dir_out !== 1'b0; k++) @(negedge clock_in);
    endtask
    //////////////////////////////////////////////////////////////////////
    // Bus monitors: device bytes at mid-cycle, link bytes as handed over
    always @(negedge ulpi_clk_out) begin
        if (dir_out === 1'b1 && data_oe_out === 8'hff) begin
            if (nxt_out === 1'b1) got.push_back(bus_w);
            else st = bus_w;
        end
    end
    always @(negedge clock_in) begin
        if (tx_valid_out === 1'b1) got.push_back(tx_byte_out);
        if (tx_cmd_out === 1'b1) chk(tx_byte_out === q[0], "command flag");
    end
    initial begin
        #(40000 * 5);
        n_fail++;
        test_done();
    end
    initial begin
        cyc(9);
        chk(dir_out === 1'b1 && data_oe_out === 8'h00, "reset state");
        cyc(1);
        rst_in = 0;
        dir_low();
        chk(dir_out === 1'b0, "no synchronous mode");
        cyc(20);
        chk(sync_mode_out === 1'b1 && mode_out === 2'h0, "default mode");
        for (i = 0; i < 4; i++) begin
            q.delete();
            got.delete();
            q.push_back(8'h40 | 8'(i));
            for (j = 0; j < i; j++) q.push_back(8'($random(seed)));
            foreach (q[x]) u_link.txb[x] = q[x];
            u_link.n = i + 1;
            u_link.go = 1;
            for (k = 0; k < 600 && tx_end_out !== 1'b1; k++) begin
                tx_ready_in = 1'($random(seed));
                @(negedge clock_in);
            end
            chk(tx_end_out === 1'b1, "transfer end");
            cyc(12);
            cmp_q();
        end
        q.delete();
        got.delete();
        full_seen = 0;
        rx_active_in = 1;
        for (i = 0; i < 8; i++) begin
            q.push_back(8'($random(seed)));
            rx_valid_in = 1;
            rx_data_in = q[i];
            while (rx_ready_out !== 1'b1) begin
                full_seen = 1;
                @(negedge clock_in);
            end
            @(negedge clock_in);
        end
        rx_valid_in = 0;
        rx_active_in = 0;
        dir_low();
        chk(full_seen, "buffer never full");
        cmp_q();
        for (i = 0; i < 2; i++) begin
            v = 8'($random(seed)) | 8'h01;
            rxcmd_in = v;
            regrd_data_in = v;
            rxcmd_req_in = (i == 0);
            regrd_req_in = (i == 1);
            for (k = 0; k < 300 && (rxcmd_ack_out | regrd_ack_out) !== 1'b1; k++) @(negedge clock_in);
            rxcmd_req_in = 0;
            regrd_req_in = 0;
            dir_low();
            chk(st === v, "status or read byte");
        end
        rx_active_in = 1;
        for (k = 0; k < 300 && dir_out !== 1'b1; k++) @(negedge clock_in);
        cyc(20);
        u_link.hold = 1;
        for (k = 0; k < 300 && rx_abort_out !== 1'b1; k++) @(negedge clock_in);
        chk(rx_abort_out === 1'b1, "no abort");
        rx_active_in = 0;
        cyc(12);
        chk(dir_out === 1'b0, "abort kept direction");
        mode_sel_in = 3'h3;
        cyc(40);
        chk(mode_out === 2'h0 && dir_out === 1'b0, "two modes taken");
        for (i = 0; i < 3; i++) begin
            alt_out_in = 8'($random(seed));
            alt_lnk = 8'($random(seed));
            mode_sel_in = 3'h1 << i;
            clk_suspend_in = (i == 0);
            cyc(40);
            chk(mode_out === 2'(i + 1) && dir_out === 1'b1 && nxt_out === 1'b0, "alt state");
            chk(data_oe_out === msk[i] && data_out === (alt_out_in & msk[i]), "alt pins");
            chk(alt_in_out === (alt_lnk & ~msk[i]), "alt inputs");
            if (i == 0) chk(ulpi_clk_out === 1'b0, "clock not stopped");
            clk_suspend_in = 0;
            cyc(8);
            u_link.hold = 1;
            for (k = 0; k < 300 && wake_out !== 1'b1; k++) @(negedge clock_in);
            chk(wake_out === 1'b1, "no wake");
            alt_lnk = 0;
            cyc(20);
            mode_sel_in = 0;
            cyc(10);
            chk(dir_out === 1'b0 && sync_mode_out === 1'b1, "not back in sync");
        end
        rst_in = 1;
        cyc(3);
        chk(dir_out === 1'b1 && data_oe_out === 8'h00 && mode_out === 2'h0, "reset");
        rst_in = 0;
        dir_low();
        chk(dir_out === 1'b0, "no sync after reset");
        test_done();
    end
endmodule // ups_bus_ctrl_tb

// *** sim/ups_link_model.sv ***
// Link-side partner driving transmit bytes and stop on the ULPI pins
`timescale 1ns/100ps
module ups_link_model (
    // Interface clock and device outputs
    input wire clk_in,
    input wire dir_in,
    input wire nxt_in,
    // Link drive of the pins
    output logic stp_out,
    output logic [7:0] data_out,
    output logic oe_out
);
    logic [7:0] txb [0:7];
    int n = 0;
    int idx = 0;
    logic go = 0;
    logic hold = 0;
    logic dq = 1;
    logic nq = 0;
    initial begin
        stp_out = 0;
        data_out = 0;
        oe_out = 0;
    end
    //////////////////////////////////////////////////////////////////
    // Mid-cycle capture: each edge acts on what was launched before it
    always @(negedge clk_in) begin
        dq <= dir_in;
        nq <= nxt_in;
    end
    always @(posedge clk_in) begin
        oe_out <= !dq;
        if (hold) begin
            stp_out <= dq;
            if (!dq && stp_out) hold <= 0;
        end else if (stp_out) begin
            stp_out <= 0;
        end else if (go && !dq) begin
            if (idx == 0) begin
                data_out <= txb[0];
                idx <= 1;
            end else if (nq && idx == n) begin
                data_out <= 8'h00;
                stp_out <= 1;
                go <= 0;
                idx <= 0;
            end else if (nq) begin
                data_out <= txb[idx];
                idx <= idx + 1;
            end
        end
    end
endmodule // ups_link_model
